// ---- rtl/cab_pkg.sv ----
// Package for the processor address-phase bus interface.
// Assumes one bus clock; shared by the design module, its checker and the bench.
package cab_pkg;
  localparam int ADDR_HI           = 31;
  localparam int ADDR_LO           = 3;
  localparam int SNOOP_LO          = 5;
  localparam int MASK_BIT          = 20;
  localparam int PERR_DELAY_CYCLES = 2;

  // Request from the core to start a bus cycle
  typedef struct packed {
    logic        valid;
    logic        system_management_mode;
    logic [31:3] addr;
    logic [3:0]  cyc_def;
  } cab_req_t;

  // Inquire address seen on the pins
  typedef struct packed {
    logic        valid;
    logic [31:5] addr;
  } cab_snoop_t;
endpackage

// ---- rtl/cab_addr_if.sv ----
// Address-phase bus interface: address drive, cycle-start strobes, bit-20 mask,
// address hold and inquire-address parity check.
// Assumes an external arbiter, core request logic and pin pads on the same clock.
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Overview of operation
// - Accept A31..A5 as inquire address inputs
// - Float address outputs during bus hold
// - Mask forces bit 20 low
// - Mask ignored for management-mode transfers
// - Mask input sampled every rising edge
// - Strobe marks first clock, address valid
// - Duplicate strobe identical to primary
// - Hold releases address bus, others active
// - Parity error two clocks later, one clock
// ****************************************
module cab_addr_if
  import cab_pkg::*;
#(
  // Flip-flops in each pin synchroniser
  parameter int SYNC_STAGES = 2,
  // Clocks from inquire sample to parity error
  parameter int PERR_DELAY  = PERR_DELAY_CYCLES
)
(
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  // Core side
  input  wire cab_pkg::cab_req_t req_in,
  output logic                  req_ready_out,
  output cab_pkg::cab_snoop_t   snoop_out,
  // Pins
  input  wire logic             addr_bit20_mask_n_in,
  input  wire logic             address_hold_request_in,
  input  wire logic [31:3]      addr_pin_in,
  input  wire logic             addr_parity_in,
  input  wire logic             inquire_strobe_n_in,
  output logic [31:3]           addr_out,
  output logic                  addr_oe_out,
  output logic [3:0]            cyc_def_out,
  output logic                  cycle_start_strobe_n_out,
  output logic                  cycle_start_strobe_copy_n_out,
  output logic                  address_parity_error_n_out
);
  import cab_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  // One flip-flop alone leaves the pins metastable
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES below 2 is not supported");
  end
  // Parity error needs at least one register
  if (PERR_DELAY < 1) begin : g_bad_perr
    $error("PERR_DELAY below 1 is not supported");
  end
  // Masked bit must lie inside the driven address
  if (MASK_BIT > ADDR_HI || MASK_BIT < ADDR_LO) begin : g_bad_mask
    $error("MASK_BIT outside the address field");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Equal depths keep strobe, address and parity aligned
  logic [SYNC_STAGES-1:0] mask_sync_r;
  logic [SYNC_STAGES-1:0] hold_sync_r;
  logic [SYNC_STAGES-1:0] inq_sync_r;
  logic [SYNC_STAGES-1:0] par_sync_r;
  logic [ADDR_HI:ADDR_LO] apin_sync_r [SYNC_STAGES];

  // First stage samples the pins
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_sync_r[0] <= 1'b0;
      hold_sync_r[0] <= 1'b0;
      inq_sync_r[0]  <= 1'b0;
      par_sync_r[0]  <= 1'b0;
      apin_sync_r[0] <= '0;
    end else begin
      mask_sync_r[0] <= ~addr_bit20_mask_n_in;
      hold_sync_r[0] <= address_hold_request_in;
      inq_sync_r[0]  <= ~inquire_strobe_n_in;
      par_sync_r[0]  <= addr_parity_in;
      apin_sync_r[0] <= addr_pin_in;
    end
  end

  // Later stages only copy the stage before
  for (genvar s = 1; s < SYNC_STAGES; s++) begin : g_sync
    always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        mask_sync_r[s] <= 1'b0;
        hold_sync_r[s] <= 1'b0;
        inq_sync_r[s]  <= 1'b0;
        par_sync_r[s]  <= 1'b0;
        apin_sync_r[s] <= '0;
      end else begin
        mask_sync_r[s] <= mask_sync_r[s-1];
        hold_sync_r[s] <= hold_sync_r[s-1];
        inq_sync_r[s]  <= inq_sync_r[s-1];
        par_sync_r[s]  <= par_sync_r[s-1];
        apin_sync_r[s] <= apin_sync_r[s-1];
      end
    end
  end

  logic                   mask_s;
  logic                   hold_s;
  logic                   inq_s;
  logic                   par_s;
  logic [ADDR_HI:ADDR_LO] apin_s;
  assign mask_s = mask_sync_r[SYNC_STAGES-1];
  assign hold_s = hold_sync_r[SYNC_STAGES-1];
  assign inq_s  = inq_sync_r[SYNC_STAGES-1];
  assign par_s  = par_sync_r[SYNC_STAGES-1];
  assign apin_s = apin_sync_r[SYNC_STAGES-1];

  // ****************************************
  // Address hold
  // ****************************************
  logic hold_r;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_s;
    end
  end

  // Only the address floats while held; requests stall and no strobes start
  assign addr_oe_out   = ~hold_r;
  assign req_ready_out = ~hold_r;

  // ****************************************
  // Cycle start and address drive
  // ****************************************
  logic [31:3] addr_nxt;
  always_comb begin
    addr_nxt = req_in.addr;
    if (mask_s && !req_in.system_management_mode) begin
      addr_nxt[MASK_BIT] = 1'b0;
    end
  end

  logic        start_r;
  logic [31:3] addr_r;
  logic [3:0]  cyc_def_r;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_r   <= 1'b0;
      addr_r    <= 29'h0;
      cyc_def_r <= 4'h0;
    end else begin
      start_r <= req_in.valid && !hold_r;
      if (req_in.valid && !hold_r) begin
        addr_r    <= addr_nxt;
        cyc_def_r <= req_in.cyc_def;
      end
    end
  end

  assign addr_out                      = addr_r;
  assign cyc_def_out                   = cyc_def_r;
  assign cycle_start_strobe_n_out      = ~start_r;
  assign cycle_start_strobe_copy_n_out = ~start_r;

  // ****************************************
  // Inquire capture
  // ****************************************
  cab_snoop_t            snoop_r;
  logic                  inq_take;
  logic                  par_ok;
  logic [PERR_DELAY-1:0] perr_pipe_r;
  assign inq_take = inq_s && hold_r;
  // Even parity over whole pin address and parity pin
  assign par_ok   = ~(^{apin_s, par_s});

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      snoop_r <= '0;
    end else begin
      snoop_r.valid <= inq_take;
      if (inq_take) begin
        snoop_r.addr <= apin_s[ADDR_HI:SNOOP_LO];
      end
    end
  end

  // ****************************************
  // Address parity check
  // ****************************************
  // Bits 4 and 3 unused for lookup, still checked
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      perr_pipe_r[0] <= 1'b0;
    end else begin
      perr_pipe_r[0] <= inq_take && !par_ok;
    end
  end

  // Delay line to the error pin, one flop per clock
  for (genvar d = 1; d < PERR_DELAY; d++) begin : g_perr
    always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        perr_pipe_r[d] <= 1'b0;
      end else begin
        perr_pipe_r[d] <= perr_pipe_r[d-1];
      end
    end
  end

  assign snoop_out                  = snoop_r;
  assign address_parity_error_n_out = ~perr_pipe_r[PERR_DELAY-1];

endmodule
`default_nettype wire

// ---- tb/cab_chk_checker.sv ----
// Checker for cab_addr_if: strobes, bit-20 mask, hold, parity error.
// Bound to the design top from the bench; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module cab_chk import cab_pkg::*; (
  input wire logic          clock_in, reset_n_in, req_ready_out, addr_bit20_mask_n_in,
  input wire logic          address_hold_request_in, addr_parity_in, addr_oe_out,
  input wire logic          cycle_start_strobe_n_out, cycle_start_strobe_copy_n_out,
  input wire logic          address_parity_error_n_out,
  input wire logic [31:3]   addr_pin_in, addr_out,
  input wire cab_req_t      req_in,
  input wire cab_snoop_t    snoop_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_take; req_in.valid && req_ready_out; endsequence
  sequence s_mask; !addr_bit20_mask_n_in [*4]; endsequence
  property p_start; s_take |=> !cycle_start_strobe_n_out && addr_out[31:21] == $past(req_in.addr[31:21]); endproperty
  a_start: assert property (p_start) else $error("start");
  property p_copy; cycle_start_strobe_n_out == cycle_start_strobe_copy_n_out; endproperty
  a_copy: assert property (p_copy) else $error("copy");
  property p_mask; s_mask ##0 s_take ##0 !req_in.system_management_mode |=> !addr_out[20]; endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_smm; s_take ##0 req_in.system_management_mode |=> addr_out[20] == $past(req_in.addr[20]); endproperty
  a_smm: assert property (p_smm) else $error("smm");
  property p_hold; address_hold_request_in [*4] |=> !addr_oe_out && !req_ready_out; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_rel; !address_hold_request_in [*4] |=> addr_oe_out; endproperty
  a_rel: assert property (p_rel) else $error("release");
  property p_perr; snoop_out.valid |=> address_parity_error_n_out == ~^{$past(addr_pin_in, 4), $past(addr_parity_in, 4)}; endproperty
  a_perr: assert property (p_perr) else $error("parity");
  property p_pw; $fell(address_parity_error_n_out) |=> address_parity_error_n_out; endproperty
  a_pw: assert property (p_pw) else $error("width");
endmodule
`default_nettype wire

// ---- tb/cab_mst.sv ----
// Inquiring master model: hold, inquire strobe, address and parity drive.
// Runs one 31-cycle inquiry per go pulse.
`timescale 1ns/100ps
`default_nettype none
module cab_mst (
  input  wire logic        clock_in, go_in, bad_in,
  input  wire logic [31:3] addr_in,
  output logic             hold_out, inq_n_out, par_out, drv_out
);
  logic [4:0] cnt_r = 5'h00;
  always_ff @(posedge clock_in) cnt_r <= (cnt_r != 5'h00 || go_in) ? cnt_r + 5'h01 : 5'h00;
  assign hold_out  = cnt_r inside {[5'h01:5'h10]};
  assign inq_n_out = cnt_r != 5'h06;
  assign drv_out   = cnt_r inside {[5'h05:5'h0c]};
  assign par_out   = ~(^addr_in ^ bad_in ^ drv_out);
endmodule
`default_nettype wire

// ---- tb/test_cab_addr_if.sv ----
// Bench top for cab_addr_if with the inquiring master model.
// Assumes the checker and master model files are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module test_cab_addr_if;
  import cab_pkg::*;
  logic clock_in = 1'b0, reset_n_in = 1'b0, mask_n = 1'b1, go = 1'b0, bad = 1'b0;
  logic hold, inq_n, par, drv, rdy, oe, stb_n, stc_n, perr_n;
  logic [31:3] a = 29'h0, ao, pins;
  logic [3:0]  cd;
  cab_req_t    req = '0;
  cab_snoop_t  snp;
  int n_fail = 0, checks = 0, cyc = 0;
  assign pins = oe ? ao : (drv ? a : ~a);
  initial forever #2 clock_in = ~clock_in;
  cab_mst i_mst (.clock_in, .go_in(go), .bad_in(bad), .addr_in(a), .hold_out(hold),
    .inq_n_out(inq_n), .par_out(par), .drv_out(drv));
  cab_addr_if i_dut (.clock_in, .reset_n_in, .req_in(req), .req_ready_out(rdy), .snoop_out(snp),
    .addr_bit20_mask_n_in(mask_n), .address_hold_request_in(hold), .addr_pin_in(pins),
    .addr_parity_in(par), .inquire_strobe_n_in(inq_n), .addr_out(ao), .addr_oe_out(oe),
    .cyc_def_out(cd), .cycle_start_strobe_n_out(stb_n), .cycle_start_strobe_copy_n_out(stc_n),
    .address_parity_error_n_out(perr_n));
  task automatic ck(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task automatic t_req(input logic [31:3] ad, input logic s, m);
    mask_n = m;
    repeat (4) @(negedge clock_in);
    req = '{1'b1, s, ad, 4'h5};
    @(negedge clock_in);
    ck(!stb_n && !stc_n && cd === 4'h5);
    ck(ao === {ad[31:21], ad[20] & (s | m), ad[19:3]});
    req.valid = 1'b0;
    @(negedge clock_in);
    ck(stb_n && stc_n);
  endtask
  task automatic t_snoop(input logic b);
    bad = b;
    a = 29'h0c3a_5e6b;
    go = 1'b1;
    @(negedge clock_in);
    go = 1'b0;
    repeat (6) @(negedge clock_in);
    ck(!oe && !rdy);
    for (int i = 0; i < 8 && snp.valid !== 1'b1; i++) @(negedge clock_in);
    ck(snp.addr === a[31:5]);
    @(negedge clock_in);
    ck(perr_n === !b);
    @(negedge clock_in);
    ck(perr_n === 1'b1);
    repeat (22) @(negedge clock_in);
    ck(oe === 1'b1);
  endtask
  task automatic close_out;
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    repeat (8) @(negedge clock_in);
    reset_n_in = 1'b1;
    for (int i = 0; i < 4; i++) t_req(29'h1abe2345, i[0], i[1]);
    t_snoop(1'b0);
    t_snoop(1'b1);
    t_req(29'h0123_4567, 1'b0, 1'b1);
    close_out;
  end
endmodule
bind cab_addr_if cab_chk i_chk (.clock_in, .reset_n_in, .req_in, .req_ready_out, .snoop_out,
  .addr_bit20_mask_n_in, .address_hold_request_in, .addr_pin_in, .addr_parity_in, .addr_out,
  .addr_oe_out, .cycle_start_strobe_n_out, .cycle_start_strobe_copy_n_out, .address_parity_error_n_out);
`default_nettype wire
